// [vphp_pkg.sv]
/*
  Constants shared by the host port of the phrase-playback voice synthesizer.
  Assumes it is compiled before any module that names vphp_pkg.
*/
// Functional notes
// R1: Busy output low while playback runs, high otherwise and after power-up.
// R2: Next-address-ready high when a new code can be accepted, low otherwise.
// R3: Host asserts command-select and start strobe only while next-address-ready is high.
// R4: Next-address-ready goes high once power has been applied.
// R5: A command chooses raw converter or filtered signal for the analog output.
// R6: Command-select high at strobe fall marks the entry as a command.
// R7: Host ties command-select high when unused or in serial mode.
// R8: Playback begins at the falling edge of the start strobe.
// R9: The seven code lines are captured at the rising edge of the strobe.
// R10: Host pulses the start strobe only after next-address-ready has risen.
// R11: Channel-select high picks channel one, low picks channel two.
// R12: Parallel mode reads commands and phrase numbers from the seven code lines.
// R13: Serial mode takes command and address bits from the serial data line.
// R14: Serial mode samples serial data with the host clock on code bit five.
// R15: Serial mode: host holds code bits zero, one and four low.
// R16: Serial mode: code bits two and three become port outputs set by command.
// R17: Reset low: standby, oscillator stopped, analog output grounded, state cleared.
// R18: Slow supply ramp needs an explicit reset pulse at power-up.
// R19: Programming-tool pin held low or open during playback.
// R20: Serial bit order, frame length and clock edge are configurable.
package vphp_pkg;

  // ----------------------------------------------------------------------
  // Widths and synchroniser bit positions
  // ----------------------------------------------------------------------
  localparam int CODE_W      = 7;
  localparam int SER_BITS    = 8;
  localparam int SYNC_W      = 11;
  localparam int SYNC_ST     = 7;
  localparam int SYNC_CMD    = 8;
  localparam int SYNC_CH     = 9;
  localparam int SYNC_MODE   = 10;
  localparam int BUS_SCLK    = 5;
  localparam int BUS_SDATA   = 6;
  localparam int SER_CMD_BIT = 7;

  // ----------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------
  localparam logic [6:0] CMD_SEL_DAC = 7'h01;
  localparam logic [6:0] CMD_SEL_LPF = 7'h02;
  localparam logic [4:0] PORT_PREFIX = 5'h1f;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic RST_BUSY_N = 1'b1;
  localparam logic RST_NAR    = 1'b1;
  localparam logic RST_FILT   = 1'b0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HELD = 2'b10
  } vphp_state_type;

endpackage

// [vphp_serial_shift.sv]
/*
  Serial entry shifter for the synthesizer host port.
  Assumes clock and data arrive already synchronised to i_mclk.
*/
`timescale 1ns/100ps
module vphp_serial_shift #(
  parameter int BITS      = vphp_pkg::SER_BITS,
  parameter bit MSB_FIRST = 1'b1,
  parameter bit RISE_EDGE = 1'b1
) (
  input  wire logic            i_mclk,
  input  wire logic            i_rst_b,
  input  wire logic            i_enable,
  input  wire logic            i_sclk,
  input  wire logic            i_sdata,
  output logic [BITS-1:0]      o_word
);

  typedef struct packed {
    logic            prev;
    logic [BITS-1:0] word;
  } vphp_shift_type;

  vphp_shift_type r;
  vphp_shift_type n;
  logic           edge_seen;

  // A frame shorter than flag plus code could never deliver a full entry.
  if (BITS < vphp_pkg::SER_BITS) begin : g_bad_bits
    $error("serial frame shorter than command flag plus code");
  end

  // ----------------------------------------------------------------------
  // Edge detection and shifting
  // ----------------------------------------------------------------------
  // The polarity choice keeps hosts that shift on either edge usable. [R20]
  assign edge_seen = RISE_EDGE ? (i_sclk && !r.prev) : (!i_sclk && r.prev);

  always_comb begin
    n      = r;
    n.prev = i_sclk;
    if (i_enable && edge_seen) begin // [R14]
      if (MSB_FIRST) begin
        n.word = {r.word[BITS-2:0], i_sdata}; // [R20]
      end else begin
        n.word = {i_sdata, r.word[BITS-1:1]};
      end
    end
    if (!i_rst_b) begin
      n = '0;
    end
  end

  always_ff @(posedge i_mclk) begin
    r <= n;
  end

  assign o_word = r.word;

endmodule

// [vphp_host_port.sv]
/*
  Host command port of the phrase-playback voice synthesizer: accepts phrase and
  command entries in parallel or serial form and paces the host.
  Assumes a playback engine on i_mclk that takes o_play_start and reports
  i_play_done; all pins from the host are asynchronous to i_mclk.
*/
`timescale 1ns/100ps
module vphp_host_port #(
  parameter int SER_BITS  = vphp_pkg::SER_BITS,
  parameter bit MSB_FIRST = 1'b1,
  parameter bit RISE_EDGE = 1'b1
) (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_b,
  input  wire logic       i_serial_mode,
  input  wire logic       i_start_strobe_n,
  input  wire logic       i_command_select,
  input  wire logic       i_channel_select,
  input  wire logic [6:0] i_phrase_code_bus,
  input  wire logic       i_play_done,
  input  wire logic       i_done_channel_one,
  output logic            o_busy_n,
  output logic            o_next_address_ready,
  output logic            o_play_start,
  output logic [6:0]      o_play_code,
  output logic            o_play_is_cmd,
  output logic            o_play_channel_one,
  output logic            o_filter_select,
  output logic            o_aux_port_out_a,
  output logic            o_aux_port_out_b,
  output logic            o_aux_port_oe_a,
  output logic            o_aux_port_oe_b,
  output logic            o_standby,
  output logic            o_analog_gnd
);

  typedef struct packed {
    logic [vphp_pkg::SYNC_W-1:0] s1;
    logic [vphp_pkg::SYNC_W-1:0] s2;
    logic                        st_prev;
    vphp_pkg::vphp_state_type    st;
    logic                        cmd_flag;
    logic                        chan;
    logic [1:0]                  active;
    logic                        busy_n;
    logic                        next_address_ready;
    logic                        play_start;
    logic [6:0]                  play_code;
    logic                        play_cmd;
    logic                        play_chan;
    logic                        filt;
    logic [1:0]                  port;
    logic                        port_oe;
    logic                        standby;
    logic                        agnd;
  } vphp_port_type;

  vphp_port_type         r;
  vphp_port_type         n;
  logic [SER_BITS-1:0]   ser_word;
  logic                  serial;
  logic                  fall_acc;
  logic                  rise_acc;
  logic                  entry_cmd;
  logic [6:0]            entry_code;

  if (SER_BITS < vphp_pkg::SER_BITS) begin : g_bad_frame
    $error("serial frame must hold command flag and seven code bits");
  end

  // ----------------------------------------------------------------------
  // Serial entry path
  // ----------------------------------------------------------------------
  vphp_serial_shift #(
    .BITS      (SER_BITS),
    .MSB_FIRST (MSB_FIRST),
    .RISE_EDGE (RISE_EDGE)
  ) u_shift (
    .i_mclk   (i_mclk),
    .i_rst_b  (i_rst_b),
    .i_enable (serial),
    .i_sclk   (r.s2[vphp_pkg::BUS_SCLK]),
    .i_sdata  (r.s2[vphp_pkg::BUS_SDATA]),
    .o_word   (ser_word)
  );

  // ----------------------------------------------------------------------
  // Entry decode
  // ----------------------------------------------------------------------
  // Strobe falls are honoured only while ready is high; a fall during a held entry is lost. [R3]
  assign serial     = r.s2[vphp_pkg::SYNC_MODE];
  assign fall_acc   = (r.st == vphp_pkg::ST_IDLE) && r.next_address_ready && r.st_prev && !r.s2[vphp_pkg::SYNC_ST];
  assign rise_acc   = (r.st == vphp_pkg::ST_HELD) && !r.st_prev && r.s2[vphp_pkg::SYNC_ST];
  // In serial mode the command pin is tied high, so the frame carries the flag. [R7]
  assign entry_cmd  = serial ? ser_word[vphp_pkg::SER_CMD_BIT] : r.s2[vphp_pkg::SYNC_CMD]; // [R6] [R13]
  assign entry_code = serial ? ser_word[6:0] : r.s2[6:0]; // [R12] [R13]

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    n            = r;
    n.s1         = {i_serial_mode, i_channel_select, i_command_select, i_start_strobe_n, i_phrase_code_bus};
    n.s2         = r.s1;
    n.st_prev    = r.s2[vphp_pkg::SYNC_ST];
    n.play_start = 1'b0;
    if (i_play_done) begin
      n.active[i_done_channel_one ? 0 : 1] = 1'b0;
    end
    case (r.st)
      vphp_pkg::ST_IDLE: begin
        if (fall_acc) begin
          n.st       = vphp_pkg::ST_HELD;
          n.next_address_ready      = 1'b0; // [R2]
          n.cmd_flag = entry_cmd; // [R6]
          n.chan     = r.s2[vphp_pkg::SYNC_CH]; // [R11]
          if (!entry_cmd) begin
            n.active[r.s2[vphp_pkg::SYNC_CH] ? 0 : 1] = 1'b1; // [R8]
          end
        end
      end
      vphp_pkg::ST_HELD: begin
        if (rise_acc) begin
          n.st         = vphp_pkg::ST_IDLE;
          n.next_address_ready        = 1'b1; // [R2]
          n.play_start = 1'b1;
          n.play_code  = entry_code; // [R9]
          n.play_cmd   = r.cmd_flag;
          n.play_chan  = r.chan; // [R11]
          if (r.cmd_flag) begin
            if (entry_code == vphp_pkg::CMD_SEL_LPF) begin
              n.filt = 1'b1; // [R5]
            end else if (entry_code == vphp_pkg::CMD_SEL_DAC) begin
              n.filt = 1'b0; // [R5]
            end
            if (serial && entry_code[6:2] == vphp_pkg::PORT_PREFIX) begin
              n.port = entry_code[1:0]; // [R16]
            end
          end
        end
      end
      default: begin
        n.st  = vphp_pkg::ST_IDLE;
        n.next_address_ready = 1'b1;
      end
    endcase
    n.busy_n  = ~|n.active; // [R1]
    n.port_oe = serial; // [R16]
    n.standby = 1'b0;
    n.agnd    = 1'b0;
    if (!i_rst_b) begin
      n         = '0; // [R17]
      n.st      = vphp_pkg::ST_IDLE;
      n.st_prev = 1'b1;
      // Strobe synchronisers restart at the idle level, so a release cannot fake a fall.
      n.s1[vphp_pkg::SYNC_ST] = 1'b1;
      n.s2[vphp_pkg::SYNC_ST] = 1'b1;
      n.busy_n  = vphp_pkg::RST_BUSY_N; // [R1]
      n.next_address_ready     = vphp_pkg::RST_NAR; // [R4]
      n.filt    = vphp_pkg::RST_FILT;
      n.standby = 1'b1; // [R17]
      n.agnd    = 1'b1; // [R17]
    end
  end

  always_ff @(posedge i_mclk) begin
    r <= n;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_busy_n             = r.busy_n;
  assign o_next_address_ready = r.next_address_ready;
  assign o_play_start         = r.play_start;
  assign o_play_code          = r.play_code;
  assign o_play_is_cmd        = r.play_cmd;
  assign o_play_channel_one   = r.play_chan;
  assign o_filter_select      = r.filt;
  assign o_aux_port_out_a     = r.port[0];
  assign o_aux_port_out_b     = r.port[1];
  assign o_aux_port_oe_a      = r.port_oe;
  assign o_aux_port_oe_b      = r.port_oe;
  assign o_standby            = r.standby;
  assign o_analog_gnd         = r.agnd;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  sequence s_fall;
    fall_acc;
  endsequence

  sequence s_entry_phrase;
    fall_acc && !entry_cmd;
  endsequence

  sequence s_rise;
    rise_acc;
  endsequence

  a_power_up_levels: assert property ($rose(i_rst_b) |-> o_busy_n && o_next_address_ready) // [R1] [R4]
    else $error("busy or ready wrong after reset release");

  a_busy_on_fall: assert property (s_entry_phrase |=> !o_busy_n) // [R8]
    else $error("busy did not drop after accepted strobe fall");

  a_ready_low_held: assert property (s_fall |=> !o_next_address_ready until rise_acc) // [R2]
    else $error("ready rose before strobe release");

  a_ready_after_rise: assert property (s_rise |=> o_next_address_ready && o_play_start ##1 !o_play_start) // [R2]
    else $error("ready or start pulse wrong after strobe rise");

  a_code_latch: assert property (s_rise |=> o_play_code == $past(entry_code)) // [R9] [R12]
    else $error("code not captured at strobe rise");

  a_cmd_capture: assert property (s_fall |=> r.cmd_flag == $past(entry_cmd)) // [R6]
    else $error("command flag not taken at strobe fall");

  a_cmd_flag: assert property (s_rise |=> o_play_is_cmd == $past(r.cmd_flag)) // [R6]
    else $error("command flag not carried to the entry");

  a_chan_capture: assert property (s_fall |=> r.chan == $past(r.s2[vphp_pkg::SYNC_CH])) // [R11]
    else $error("channel select not taken at strobe fall");

  a_channel_pick: assert property (s_rise |=> o_play_channel_one == $past(r.chan)) // [R11]
    else $error("channel not taken from channel select");

  a_filter_cmd: assert property (rise_acc && r.cmd_flag && entry_code == vphp_pkg::CMD_SEL_LPF |=> o_filter_select) // [R5]
    else $error("filtered output not selected by command");

  a_port_cmd: assert property (rise_acc && serial && r.cmd_flag && entry_code[6:2] == vphp_pkg::PORT_PREFIX
                               |=> {o_aux_port_out_b, o_aux_port_out_a} == $past(entry_code[1:0])) // [R16]
    else $error("port outputs not set by port code");

  a_serial_code: assert property (rise_acc && serial |=> o_play_code == $past(ser_word[6:0])) // [R13] [R14]
    else $error("serial entry code not used");

  a_reset_ground: assert property (@(posedge i_mclk) disable iff (1'b0) !i_rst_b |=> o_analog_gnd && o_standby) // [R17]
    else $error("analog output not grounded in reset");

endmodule

// [vphp_host_model.sv]
/*
  Host controller model that drives the synthesizer host port pins.
  Assumes one bench process calls its tasks one at a time.
*/
`timescale 1ns/100ps
module vphp_host_model (
  input  wire logic       i_mclk,
  input  wire logic       i_next_address_ready,
  output logic            o_start_strobe_n,
  output logic            o_command_select,
  output logic            o_channel_select,
  output logic [6:0]      o_bus,
  output logic            o_program_tool_pin
);
  // ------------------------------------------------------------
  // Entry tasks
  // ------------------------------------------------------------
  initial begin
    o_start_strobe_n = 1'b1;
    o_command_select = 1'b1;
    o_channel_select = 1'b1;
    o_bus            = 7'h00;
    o_program_tool_pin = 1'b0;
  end

  // The high phase is stretched so the synchronisers never miss a strobe edge.
  task automatic fall(input logic ser, input logic [7:0] frame, input logic ch);
    int n;
    n = 0;
    repeat (6) @(posedge i_mclk);
    #1;
    while (i_next_address_ready !== 1'b1 && n < 200) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    o_channel_select = ch;
    o_command_select = ser | frame[7];
    if (ser) begin
      for (int i = 7; i >= 0; i--) begin
        o_bus = {frame[i], 6'h00};
        #62.5 o_bus[5] = 1'b1;
        #62.5;
      end
      // The link clock stands still and old data is not left on the line.
      o_bus = {~frame[0], 6'h00};
    end else begin
      o_bus = frame[6:0];
    end
    repeat (4) @(posedge i_mclk);
    #1;
    o_start_strobe_n = 1'b0;
    repeat (8) @(posedge i_mclk);
    #1;
  endtask

  task automatic rise();
    o_start_strobe_n = 1'b1;
    o_command_select = 1'b1;
  endtask
endmodule

// [test_voice_phrase_host_port.sv]
/*
  Self-checking bench for the synthesizer host port.
  Assumes the package, the design and the host model are compiled first.
*/
`timescale 1ns/100ps
module test_voice_phrase_host_port;
  logic       i_mclk, rst_b, serial_mode, play_done, done_ch1, strobe_n, cmd_sel, ch_sel, program_tool_pin;
  logic [6:0] host_bus, code_bus, play_code;
  logic       busy_n, ready, play_start, play_is_cmd, play_ch1, filt, port_a, port_b, oe_a, oe_b, standby, agnd;
  int         num_errors = 0;
  int         total_checks = 0;

  // The device owns pins 2 and 3 whenever it enables them.
  assign code_bus = {host_bus[6:4], oe_b ? port_b : host_bus[3], oe_a ? port_a : host_bus[2], host_bus[1:0]};
  always #5 i_mclk = ~i_mclk;

  vphp_host_port u_dut (
    .i_mclk(i_mclk), .i_rst_b(rst_b), .i_serial_mode(serial_mode), .i_start_strobe_n(strobe_n),
    .i_command_select(cmd_sel), .i_channel_select(ch_sel), .i_phrase_code_bus(code_bus),
    .i_play_done(play_done), .i_done_channel_one(done_ch1), .o_busy_n(busy_n),
    .o_next_address_ready(ready), .o_play_start(play_start), .o_play_code(play_code),
    .o_play_is_cmd(play_is_cmd), .o_play_channel_one(play_ch1), .o_filter_select(filt),
    .o_aux_port_out_a(port_a), .o_aux_port_out_b(port_b), .o_aux_port_oe_a(oe_a),
    .o_aux_port_oe_b(oe_b), .o_standby(standby), .o_analog_gnd(agnd)
  );

  vphp_host_model u_host (
    .i_mclk               (i_mclk),
    .i_next_address_ready (ready),
    .o_start_strobe_n     (strobe_n),
    .o_command_select     (cmd_sel),
    .o_channel_select     (ch_sel),
    .o_bus                (host_bus),
    .o_program_tool_pin   (program_tool_pin)
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  // Frame bit 7 is the command flag in both modes.
  task automatic entry(input logic ser, input logic [7:0] frame, input logic ch, input logic exp_busy_n);
    int n;
    n = 0;
    u_host.fall(ser, frame, ch);
    check({6'h00, busy_n, ready}, {6'h00, exp_busy_n, 1'b0});
    u_host.rise();
    while (play_start !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    check({play_start, play_code}, {1'b1, frame[6:0]});
    check({5'h00, ready, play_is_cmd, play_ch1}, {5'h00, 1'b1, frame[7], ch});
    tick(1);
  endtask

  task automatic finish_play(input logic ch1, input logic exp_busy_n);
    play_done = 1'b1;
    done_ch1  = ch1;
    tick(1);
    play_done = 1'b0;
    tick(1);
    check(8'(busy_n), 8'(exp_busy_n));
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_parallel_phrase();
    entry(1'b0, 8'h55, 1'b1, 1'b0);
    entry(1'b0, 8'h7f, 1'b0, 1'b0);
    finish_play(1'b1, 1'b0);
    finish_play(1'b0, 1'b1);
  endtask

  // A phrase that reuses a command's code must leave the filter alone.
  task automatic t_commands();
    entry(1'b0, {1'b1, vphp_pkg::CMD_SEL_LPF}, 1'b1, 1'b1);
    check(8'(filt), 8'h01);
    entry(1'b0, {1'b0, vphp_pkg::CMD_SEL_DAC}, 1'b1, 1'b0);
    check(8'(filt), 8'h01);
    entry(1'b0, {1'b1, vphp_pkg::CMD_SEL_DAC}, 1'b0, 1'b0);
    check(8'(filt), 8'h00);
    finish_play(1'b1, 1'b1);
  endtask

  task automatic t_serial();
    serial_mode = 1'b1;
    tick(4);
    check({6'h00, oe_b, oe_a}, 8'h03);
    entry(1'b1, 8'h2a, 1'b1, 1'b0);
    finish_play(1'b1, 1'b1);
    for (int i = 0; i < 4; i++) begin
      entry(1'b1, {1'b1, vphp_pkg::PORT_PREFIX, 2'(i)}, 1'b0, 1'b1);
      check({6'h00, port_b, port_a}, 8'(i));
    end
    entry(1'b1, {1'b1, vphp_pkg::CMD_SEL_LPF}, 1'b1, 1'b1);
    check(8'(filt), 8'h01);
    serial_mode = 1'b0;
    tick(4);
    check({6'h00, oe_b, oe_a}, 8'h00);
  endtask

  // Reset in mid-playback must clear busy without any done pulse.
  task automatic t_reset_mid();
    entry(1'b0, 8'h11, 1'b1, 1'b0);
    rst_b = 1'b0;
    tick(2);
    check({play_start, 1'b0, filt, oe_a, busy_n, ready, standby, agnd}, 8'h0f);
    rst_b = 1'b1;
    tick(1);
    check({4'h0, busy_n, ready, standby, agnd}, 8'h0c);
  endtask

  initial begin
    i_mclk      = 1'b0;
    rst_b       = 1'b0;
    serial_mode = 1'b0;
    play_done   = 1'b0;
    done_ch1    = 1'b0;
    tick(2);
    rst_b = 1'b1;
    tick(3);
    check({4'h0, busy_n, ready, standby, agnd}, 8'h0c);
    t_parallel_phrase();
    t_commands();
    t_serial();
    t_reset_mid();
    stop_test();
  end

  // The full run takes about 9 us; some eleven times that means a hang.
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end
endmodule
